// ===== design/arinc_tx_pkg.sv
// Purpose: shared constants and types for the serial word transmitter
// Assumes: 40 MHz ref_clk, transmit clock pin at four times the bit rate
// Notes:   control and status bit positions are byte-lane positions
package arinc_tx_pkg;

    // host byte path and buffer shape
    localparam int         DATA_W       = 8;
    localparam int         FIFO_DEPTH   = 32;
    localparam int         CNT_W        = 6;
    localparam logic [5:0] CNT_EMPTY    = 6'h00;
    localparam logic [5:0] WORD_BYTES   = 6'h04;

    // control word layout and its value after master reset (bit 6 as 0)
    localparam logic [7:0] CTRL_RESET   = 8'h25;
    localparam int         TX_EN_POS    = 0;
    localparam int         SELFTEST_POS = 4;
    localparam int         PMODE_POS    = 5;

    // status word layout
    localparam int         LOAD_OK_POS  = 0;
    localparam int         IDLE_POS     = 2;
    localparam int         UNDERWR_POS  = 7;

    // bit cell: four transmit clock quarters, line high for the first two
    localparam logic [1:0] QTR_LAST     = 2'h3;
    localparam logic [4:0] LAST_BIT     = 5'h1f;
    localparam logic [2:0] BYTE_LAST    = 3'h7;
    // null gap between words: four bit times in quarters
    localparam logic [4:0] GAP_LAST     = 5'h0f;

    // pin synchroniser lanes and their idle levels
    localparam int          SYNC_W      = 16;
    localparam logic [15:0] SYNC_RESET  = 16'h0078;
    localparam int          S_TXC       = 0;
    localparam int          S_FSEL      = 1;
    localparam int          S_INIT      = 2;
    localparam int          S_HOLD      = 3;
    localparam int          S_CS_N      = 4;
    localparam int          S_WR_N      = 5;
    localparam int          S_RD_N      = 6;
    localparam int          S_CMD       = 7;
    localparam int          S_DATA      = 8;

    typedef enum logic [1:0] {ST_GAP, ST_WAIT, ST_SEND} tx_state_e;

endpackage

// ===== design/byte_fifo_if.sv
// Purpose: valid/ready byte path between host loader and buffer
// Assumes: single clock, both ends on ref_clk
// Notes:   count lets the loader judge word completeness
`timescale 1ns/100ps
interface byte_fifo_if #(
    parameter int W  = 8,
    parameter int CW = 6
);
    logic [W-1:0]  in_data;
    logic          in_valid;
    logic          in_ready;
    logic [W-1:0]  out_data;
    logic          out_valid;
    logic          out_ready;
    logic [CW-1:0] count;

    modport store (input in_data, in_valid, out_ready,
                   output in_ready, out_data, out_valid, count);
    modport user  (output in_data, in_valid, out_ready,
                   input in_ready, out_data, out_valid, count);
endinterface

// ===== design/byte_fifo.sv
// Purpose: transmit byte buffer, parameterised width and depth
// Assumes: DEPTH a power of two; flush drops all contents in one cycle
// Notes:   in_ready falls when full so the loader sees back-pressure
`timescale 1ns/100ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  flush,
    byte_fifo_if.store f
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    wire              push;
    wire              pop;

    // honest flags straight from the occupancy count
    assign f.in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign f.out_valid = (count_reg != '0);
    assign f.out_data  = mem[rd_ptr_reg];
    assign f.count     = count_reg;
    assign push        = f.in_valid & f.in_ready;
    assign pop         = f.out_valid & f.out_ready;

    // storage carries no reset, only the pointers matter
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_reg] <= f.in_data;
    end

    // pointers wrap naturally on the power-of-two depth
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else if (flush)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_reg + AW'(push);
            rd_ptr_reg <= rd_ptr_reg + AW'(pop);
            count_reg  <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ===== design/arinc_tx.sv
// Purpose: serial word transmitter behind an 8-bit host port
// Assumes: all pins asynchronous to ref_clk; strobes wider than 4 cycles
// Notes:   master reset pin acts as a synchronous clear after sync
//
// Notes on behaviour
// - self test loops serial outputs to receiver, line outputs stay null
// - parity on: bit 32 is generated so the word has odd ones
// - error output high on underwrite or receiver error; blocks sending
// - status read or master reset clears a pending underwrite; receiver error input is not cleared
// - byte mode: missing byte at end of 8th bit sets underwrite
// - loaded and enabled word waits while send gate is high, an error is pending or the null gap runs
// - four transmit clock cycles per serial bit
// - enable bit gates transmitter; rising enable sends buffered word
// - select pin low: byte mode; mode bit picks data or parity
// - select pin high: parity on; mode bit 0 word, 1 byte mode
// - master reset loads control with 0x25 and clears logic
// - idle low while a word is sent; idle status mirrors it
// - ready output high whenever the buffer can take a write
// - zero line for 0 bits, one line for 1 bits, both low null
// - status bit 0 shows buffer may be loaded
// - status bit 7 shows byte mode underwrite
// - bits 1-8 first, lsb first; in byte mode first write drops ready and idle
// - command select high for status and control, low for data
`timescale 1ns/100ps
module arinc_tx (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       tx_clock_x4,
    input  wire logic       feature_select_pin,
    input  wire logic       chip_init_in,
    input  wire logic       send_hold_in,
    input  wire logic       chip_select_n,
    input  wire logic       write_n,
    input  wire logic       read_n,
    input  wire logic       cmd_select,
    input  wire logic [7:0] host_data_in,
    input  wire logic       rx_error_in,
    output logic      [7:0] host_data_out,
    output logic            host_data_oe,
    output logic            shared_error_out,
    output logic            tx_idle_out,
    output logic            tx_buffer_ready_out,
    output logic            zero_line_out,
    output logic            one_line_out,
    output logic            loop_zero_out,
    output logic            loop_one_out,
    output logic      [7:0] ctrl_word_out,
    output logic            parity_enable_out
);
    logic [15:0]               sync1_reg;
    logic [15:0]               sync2_reg;
    logic                      txc_prev_reg;
    logic                      wr_prev_reg;
    logic                      rd_prev_reg;
    logic [7:0]                ctrl_reg;
    logic                      underwrite_reg;
    arinc_tx_pkg::tx_state_e   state_reg;
    logic [1:0]                quarter_reg;
    logic [4:0]                bit_reg;
    logic [7:0]                shift_reg;
    logic                      par_reg;
    logic [4:0]                gap_reg;
    logic [7:0]                status_w;
    wire                       flush_w;

    byte_fifo_if #(.W(arinc_tx_pkg::DATA_W), .CW(arinc_tx_pkg::CNT_W)) bf();

    byte_fifo #(
        .WIDTH (arinc_tx_pkg::DATA_W),
        .DEPTH (arinc_tx_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk   (ref_clk),
        .rst   (rst),
        .flush (flush_w),
        .f     (bf.store)
    );

    // every pin except rst and rx_error_in passes two flip-flops before anything looks at it
    genvar gi;
    generate
        for (gi = 0; gi < arinc_tx_pkg::SYNC_W; gi++)
        begin : g_sync
            wire pin_w;
            if (gi >= arinc_tx_pkg::S_DATA)
            begin : g_data
                assign pin_w = host_data_in[gi - arinc_tx_pkg::S_DATA];
            end
            else
            begin : g_ctl
                assign pin_w = (gi == arinc_tx_pkg::S_TXC)  ? tx_clock_x4 :
                               (gi == arinc_tx_pkg::S_FSEL) ?
                                   feature_select_pin :
                               (gi == arinc_tx_pkg::S_INIT) ? chip_init_in :
                               (gi == arinc_tx_pkg::S_HOLD) ? send_hold_in :
                               (gi == arinc_tx_pkg::S_CS_N) ? chip_select_n :
                               (gi == arinc_tx_pkg::S_WR_N) ? write_n :
                               (gi == arinc_tx_pkg::S_RD_N) ? read_n :
                               cmd_select;
            end
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                begin
                    sync1_reg[gi] <= arinc_tx_pkg::SYNC_RESET[gi];
                    sync2_reg[gi] <= arinc_tx_pkg::SYNC_RESET[gi];
                end
                else
                begin
                    sync1_reg[gi] <= pin_w;
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    // synchronised pin views
    wire       txc_s  = sync2_reg[arinc_tx_pkg::S_TXC];
    wire       fsel_s = sync2_reg[arinc_tx_pkg::S_FSEL];
    wire       init_s = sync2_reg[arinc_tx_pkg::S_INIT];
    wire       hold_s = sync2_reg[arinc_tx_pkg::S_HOLD];
    wire       cmd_s  = sync2_reg[arinc_tx_pkg::S_CMD];
    wire [7:0] data_s = sync2_reg[arinc_tx_pkg::S_DATA +: 8];

    // host strobe decode on the leading edge of each access
    wire wr_act   = ~sync2_reg[arinc_tx_pkg::S_CS_N] &
                    ~sync2_reg[arinc_tx_pkg::S_WR_N];
    wire rd_act   = ~sync2_reg[arinc_tx_pkg::S_CS_N] &
                    ~sync2_reg[arinc_tx_pkg::S_RD_N];
    wire wr_stb   = wr_act & ~wr_prev_reg;
    wire rd_stb   = rd_act & ~rd_prev_reg;
    wire ctrl_wr  = wr_stb & cmd_s;
    wire stat_rd  = rd_stb & cmd_s;
    wire tick     = txc_s & ~txc_prev_reg;

    // mode decode from the select pin and the parity mode bit
    wire tx_en     = ctrl_reg[arinc_tx_pkg::TX_EN_POS];
    wire selftest  = ctrl_reg[arinc_tx_pkg::SELFTEST_POS];
    wire pmode     = ctrl_reg[arinc_tx_pkg::PMODE_POS];
    wire byte_mode = ~fsel_s | pmode;
    wire parity_en = fsel_s | pmode;
    wire sending   = (state_reg == arinc_tx_pkg::ST_SEND);

    // buffer may take a byte: byte mode holds one, word mode holds four
    wire fifo_empty = (bf.count == arinc_tx_pkg::CNT_EMPTY);
    wire load_ok    = bf.in_ready & (byte_mode ? fifo_empty :
                      (bf.count < arinc_tx_pkg::WORD_BYTES) & ~sending);
    wire data_wr    = wr_stb & ~cmd_s & load_ok;  // writes when not ready drop
    wire word_avail = byte_mode ? ~fifo_empty :
                      (bf.count >= arinc_tx_pkg::WORD_BYTES);

    // a pending error from either half stops the transmitter
    wire err_block  = underwrite_reg | rx_error_in;
    wire start_w    = (state_reg == arinc_tx_pkg::ST_WAIT) & tick & tx_en &
                      ~hold_s & ~err_block & word_avail;
    wire bit_end    = sending & tick & (quarter_reg == arinc_tx_pkg::QTR_LAST);
    wire byte_end   = bit_end & (bit_reg != arinc_tx_pkg::LAST_BIT) &
                      (bit_reg[2:0] == arinc_tx_pkg::BYTE_LAST);
    wire underwr_ev = byte_end & ~bf.out_valid;
    wire abort_w    = sending & err_block;
    assign flush_w  = init_s | abort_w;  // master reset or abort empties it

    // bit 32 becomes odd parity when enabled, else host data
    wire cur_bit    = (parity_en & (bit_reg == arinc_tx_pkg::LAST_BIT)) ?
                      ~par_reg : shift_reg[0];
    wire cell_high  = sending & ~quarter_reg[1];
    wire idle_w     = ~sending & ~(byte_mode & ~fifo_empty);

    assign bf.in_data   = data_s;
    assign bf.in_valid  = data_wr;
    assign bf.out_ready = start_w | (byte_end & ~abort_w);

    // status word; unused bits read as zero
    always_comb
    begin
        status_w = 8'h00;
        status_w[arinc_tx_pkg::LOAD_OK_POS] = load_ok;
        status_w[arinc_tx_pkg::IDLE_POS]    = idle_w;
        status_w[arinc_tx_pkg::UNDERWR_POS] = underwrite_reg;
    end

    // edge history for strobes and the transmit clock
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            txc_prev_reg <= 1'b0;
            wr_prev_reg  <= 1'b0;
            rd_prev_reg  <= 1'b0;
        end
        else
        begin
            txc_prev_reg <= txc_s;
            wr_prev_reg  <= wr_act;
            rd_prev_reg  <= rd_act;
        end
    end

    // control word is write-only; master reset restores it
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            ctrl_reg <= arinc_tx_pkg::CTRL_RESET;
        else if (init_s)
            ctrl_reg <= arinc_tx_pkg::CTRL_RESET;
        else if (ctrl_wr)
            ctrl_reg <= data_s;
    end

    // underwrite flag: a new event beats a clearing status read
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            underwrite_reg <= 1'b0;
        else if (init_s)
            underwrite_reg <= 1'b0;
        else if (underwr_ev)
            underwrite_reg <= 1'b1;
        else if (stat_rd)
            underwrite_reg <= 1'b0;
    end

    // serialiser: gap, wait for gate, send 32 bits lsb first
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg   <= arinc_tx_pkg::ST_GAP;
            quarter_reg <= 2'h0;
            bit_reg     <= 5'h00;
            shift_reg   <= 8'h00;
            par_reg     <= 1'b0;
            gap_reg     <= 5'h00;
        end
        else if (init_s | abort_w | underwr_ev)
        begin
            state_reg <= arinc_tx_pkg::ST_GAP;
            gap_reg   <= 5'h00;
        end
        else
        begin
            case (state_reg)
                arinc_tx_pkg::ST_GAP:
                begin
                    if (tick)
                    begin
                        gap_reg <= gap_reg + 5'h01;
                        if (gap_reg == arinc_tx_pkg::GAP_LAST)
                            state_reg <= arinc_tx_pkg::ST_WAIT;
                    end
                end
                arinc_tx_pkg::ST_WAIT:
                begin
                    if (start_w)
                    begin
                        state_reg   <= arinc_tx_pkg::ST_SEND;
                        shift_reg   <= bf.out_data;
                        quarter_reg <= 2'h0;
                        bit_reg     <= 5'h00;
                        par_reg     <= 1'b0;
                    end
                end
                arinc_tx_pkg::ST_SEND:
                begin
                    if (tick)
                        quarter_reg <= quarter_reg + 2'h1;
                    if (bit_end)
                    begin
                        par_reg <= par_reg ^ shift_reg[0];
                        bit_reg <= bit_reg + 5'h01;
                        if (bit_reg == arinc_tx_pkg::LAST_BIT)
                        begin
                            state_reg <= arinc_tx_pkg::ST_GAP;
                            gap_reg   <= 5'h00;
                        end
                        else if (byte_end)
                            shift_reg <= bf.out_data;
                        else
                            shift_reg <= {1'b0, shift_reg[7:1]};
                    end
                end
                default:
                    state_reg <= arinc_tx_pkg::ST_GAP;
            endcase
        end
    end

    // registered pins; self test keeps the line null and feeds loopback
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            zero_line_out       <= 1'b0;
            one_line_out        <= 1'b0;
            loop_zero_out       <= 1'b0;
            loop_one_out        <= 1'b0;
            tx_idle_out         <= 1'b1;
            tx_buffer_ready_out <= 1'b1;
            shared_error_out    <= 1'b0;
            ctrl_word_out       <= arinc_tx_pkg::CTRL_RESET;
            parity_enable_out   <= 1'b1;
            host_data_out       <= 8'h00;
            host_data_oe        <= 1'b0;
        end
        else
        begin
            zero_line_out       <= cell_high & ~cur_bit & ~selftest;
            one_line_out        <= cell_high & cur_bit & ~selftest;
            loop_zero_out       <= cell_high & ~cur_bit & selftest;
            loop_one_out        <= cell_high & cur_bit & selftest;
            tx_idle_out         <= idle_w;
            tx_buffer_ready_out <= load_ok;
            shared_error_out    <= err_block;
            ctrl_word_out       <= ctrl_reg;
            parity_enable_out   <= parity_en;
            host_data_oe        <= rd_act & cmd_s;
            if (stat_rd)
                host_data_out <= status_w;
        end
    end

    // checks on the transmit path
    chk_selftest_null: assert property (@(posedge ref_clk) disable iff (rst)
        selftest |=> !zero_line_out && !one_line_out)
        else $error("line driven during self test");
    chk_parity_odd: assert property (@(posedge ref_clk) disable iff (rst)
        sending && parity_en && bit_reg == arinc_tx_pkg::LAST_BIT &&
        quarter_reg == 2'h0 && !selftest
        |=> one_line_out != $past(par_reg))
        else $error("generated parity not odd");
    chk_error_abort: assert property (@(posedge ref_clk) disable iff (rst)
        sending && err_block |=> state_reg == arinc_tx_pkg::ST_GAP)
        else $error("word continued under error");
    chk_read_clears: assert property (@(posedge ref_clk) disable iff (rst)
        stat_rd && !underwr_ev |=> !underwrite_reg)
        else $error("status read left underwrite set");
    chk_underwrite_err: assert property (@(posedge ref_clk) disable iff (rst)
        underwr_ev |=> underwrite_reg ##1 shared_error_out)
        else $error("underwrite not flagged");
    chk_gate_holds: assert property (@(posedge ref_clk) disable iff (rst)
        state_reg == arinc_tx_pkg::ST_WAIT && hold_s
        |=> state_reg != arinc_tx_pkg::ST_SEND)
        else $error("word began with gate high");
    chk_ctrl_init: assert property (@(posedge ref_clk) disable iff (rst)
        init_s |=> ctrl_reg == arinc_tx_pkg::CTRL_RESET)
        else $error("control not restored by master reset");
    chk_idle_low: assert property (@(posedge ref_clk) disable iff (rst)
        sending |=> !tx_idle_out)
        else $error("idle high while sending");
    chk_byte_ready: assert property (@(posedge ref_clk) disable iff (rst)
        byte_mode && !fifo_empty |=> !tx_buffer_ready_out)
        else $error("ready high with byte pending");
    chk_rz_cell: assert property (@(posedge ref_clk) disable iff (rst)
        sending && quarter_reg[1] |=> !zero_line_out && !one_line_out)
        else $error("line not null in second half of bit");
    chk_gap_span: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(sending) && !init_s |-> state_reg == arinc_tx_pkg::ST_GAP
        && gap_reg == 5'h00)
        else $error("gap not restarted after word");
endmodule

// ===== test/line_rx_model.sv
// Purpose: line driver stand-in, turns return-to-zero bits into words
// Assumes: bits arrive lsb first, a pulse on one line per bit
// Notes:   a long null drops a partial word, as after an abort
`timescale 1ns/100ps
module line_rx_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        zero_in,
    input  wire logic        one_in,
    output logic      [31:0] word,
    output logic             word_valid
);
    logic       act_q;
    logic [5:0] nbits;
    logic [7:0] null_cnt;
    wire        act = zero_in | one_in;
    // a bit is taken on the rising edge of either line
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            {act_q, nbits, null_cnt, word, word_valid} <= '0;
        end
        else
        begin
            act_q      <= act;
            word_valid <= 1'h0;
            null_cnt   <= act ? 8'h00 : null_cnt + {7'h00, null_cnt != 8'hff};
            if (act && !act_q)
            begin
                word       <= {one_in, word[31:1]};
                nbits      <= (nbits == 6'h1f) ? 6'h00 : nbits + 6'h01;
                word_valid <= (nbits == 6'h1f);
            end
            else if (null_cnt > 8'h40) // framing restarts after a gap
                nbits <= 6'h00;
        end
    end
endmodule

// ===== test/arinc_tx_tb.sv
// Purpose: self-checking bench for the serial word transmitter
// Assumes: transmit clock at ref_clk/8, host strobes five cycles wide
// Notes:   driver queues expected words, monitor pops them per word
`timescale 1ns/100ps
module arinc_tx_tb;
    logic        ref_clk = 1'h0, rst = 1'h1, tx_clock_x4 = 1'h0;
    logic        feature_select_pin = 1'h0, chip_init_in = 1'h0;
    logic        send_hold_in = 1'h0, rx_error_in = 1'h0, cmd_select = 1'h1;
    logic        chip_select_n = 1'h1, write_n = 1'h1, read_n = 1'h1;
    logic  [7:0] host_data_in = 8'h00, host_data_out, ctrl_word_out, s;
    logic        host_data_oe, shared_error_out, tx_idle_out, word_valid;
    logic        tx_buffer_ready_out, zero_line_out, one_line_out;
    logic        loop_zero_out, loop_one_out, parity_enable_out;
    logic [31:0] word, q[$];
    logic  [2:0] tdiv = 3'h0;
    int          bad_count = 0, checked = 0, cyc = 0, line_hits, loop_hits;

    arinc_tx i_arinc_tx (.ref_clk, .rst, .tx_clock_x4, .feature_select_pin,
        .chip_init_in, .send_hold_in, .chip_select_n, .write_n, .read_n,
        .cmd_select, .host_data_in, .rx_error_in, .host_data_out,
        .host_data_oe, .shared_error_out, .tx_idle_out, .tx_buffer_ready_out,
        .zero_line_out, .one_line_out, .loop_zero_out, .loop_one_out,
        .ctrl_word_out, .parity_enable_out);
    line_rx_model i_line_rx_model (.clk(ref_clk), .rst, .zero_in(zero_line_out),
        .one_in(one_line_out), .word, .word_valid);

    // 40 MHz system clock
    always #12.5 ref_clk = ~ref_clk;

    // transmit clock well below ref_clk/4 so the pin synchroniser keeps up
    always @(posedge ref_clk)
    begin
        #2;
        tdiv++;
        tx_clock_x4 = tdiv[2];
    end

    task automatic finish_test();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, exp, input string nm);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // monitor: every decoded word must match the oldest queued one
    always @(posedge ref_clk)
    begin
        cyc++;
        line_hits += int'(zero_line_out | one_line_out);
        loop_hits += int'(loop_zero_out | loop_one_out);
        if (word_valid === 1'h1)
            chk(word, q.size() ? q.pop_front() : ~word, "line word");
        if (cyc == 60000)
        begin
            bad_count++;
            finish_test();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask

    // host write; data held from before the strobe until it rises
    task automatic wr(input logic c, input logic [7:0] d);
        tick(1);
        {cmd_select, host_data_in, chip_select_n} = {c, d, 1'h0};
        tick(3);
        write_n = 1'h0;
        tick(5);
        {write_n, chip_select_n} = 2'h3;
        tick(5);
    endtask

    task automatic rd();
        tick(1);
        {cmd_select, chip_select_n} = 2'h2;
        tick(3);
        read_n = 1'h0;
        tick(5);
        s = host_data_out;
        chk(host_data_oe, 1, "read enable");
        {read_n, chip_select_n} = 2'h3;
        tick(5);
    endtask

    // bytes go lsb byte first, each once ready is seen high or 3000 cycles pass
    task automatic send(input logic [31:0] w, input logic par, st);
        if (par)
            w[31] = ~^w[30:0];
        if (!st)
            q.push_back(w);
        for (int i = 0; i < 4; i++)
        begin
            for (int k = 0; k < 3000 && tx_buffer_ready_out !== 1'h1; k++)
                tick(1);
            wr(1'h0, w[8*i +: 8]);
        end
    endtask

    // the trailing wait covers the sixteen-tick null gap between words
    task automatic wait_idle();
        tick(40);
        for (int k = 0; k < 3000 && tx_idle_out !== 1'h1; k++)
            tick(1);
        tick(150);
    endtask

    initial
    begin
        void'($urandom(47));
        tick(10);
        rst = 1'h0;
        tick(200);
        chk(ctrl_word_out, arinc_tx_pkg::CTRL_RESET, "ctrl reset");
        chk(parity_enable_out, 1, "parity at reset");
        rd();
        chk(s, 8'h05, "status idle");
        // byte mode with parity, second word loaded on the first one's tail
        repeat (2)
        begin
            send($urandom, 1'h1, 1'h0);
            chk(tx_idle_out, 0, "idle while sending");
        end
        wait_idle();
        wr(1'h1, 8'h01); // parity off: the host owns bit 32
        chk(parity_enable_out, 0, "parity off");
        send($urandom, 1'h0, 1'h0);
        wait_idle();
        // word mode: disabled, then gated, then released
        feature_select_pin = 1'h1;
        wr(1'h1, 8'h00);
        chk(parity_enable_out, 1, "parity forced");
        send($urandom, 1'h1, 1'h0);
        tick(300);
        chk(tx_idle_out, 1, "disabled holds word");
        chk(tx_buffer_ready_out, 0, "full buffer");
        send_hold_in = 1'h1;
        wr(1'h1, 8'h01);
        tick(300);
        chk(tx_idle_out, 1, "gate holds word");
        send_hold_in = 1'h0;
        wait_idle();
        // underwrite: only the first byte of a byte-mode word arrives
        feature_select_pin = 1'h0;
        wr(1'h1, 8'h25);
        wr(1'h0, 8'($urandom));
        for (int k = 0; k < 2000 && shared_error_out !== 1'h1; k++)
            tick(1);
        chk(shared_error_out, 1, "underwrite error");
        rd();
        chk(s[7], 1, "underwrite flag");
        chk(shared_error_out, 0, "error cleared");
        rd();
        chk(s[7], 0, "flag cleared");
        rx_error_in = 1'h1;
        tick(4);
        chk(shared_error_out, 1, "receiver error");
        rx_error_in = 1'h0;
        tick(4);
        // self test: lines stay null, loop outputs carry the word
        wr(1'h1, 8'h35);
        {line_hits, loop_hits} = '0;
        send($urandom, 1'h1, 1'h1);
        wait_idle();
        chk(line_hits, 0, "lines null");
        chk(loop_hits > 0, 1, "loop active");
        chip_init_in = 1'h1;
        tick(6);
        chip_init_in = 1'h0;
        tick(6);
        chk(ctrl_word_out, arinc_tx_pkg::CTRL_RESET, "master reset");
        chk(q.size(), 0, "words left");
        finish_test();
    end
endmodule
